// ==== design/cmn_pkg.sv ====
// Function
// - Remainder of Y by Z goes to X; result and issue take 34 cycles.
// - Remainder treats both operands as unsigned integers.
// - Remainder exists only when the divider option is built in.
// - Register multiply keeps low 32 product bits; result 3 cycles, issue 1.
// - Multiplies exist only with multicycle or pipelined multiplier option.
// - Immediate multiply uses sign-extended immediate; low 32 bits; 3 cycles.
// - Copy_register copies Y to X as OR with register zero, 1 cycle.
// - Move-high puts immediate shifted left 16 into X via OR-high, 1 cycle.
// - Register NOR writes complement of Y OR Z; 1 cycle.
// - Immediate NOR ORs zero-extended immediate with Y, complements; 1 cycle.
package cmn_pkg;

  // ==========================================================================
  // Encoding
  localparam logic [5:0] CMN_OP_MODU = 6'h31;
  localparam logic [5:0] CMN_OP_MUL = 6'h22;
  localparam logic [5:0] CMN_OP_NOR = 6'h21;
  localparam logic [5:0] CMN_OP_MULI = 6'h02;
  localparam logic [5:0] CMN_OP_NORI = 6'h01;
  localparam logic [5:0] CMN_OP_OR = 6'h2E;
  localparam logic [5:0] CMN_OP_ORHI = 6'h1E;
  localparam int CMN_OP_MSB = 31;
  localparam int CMN_OP_LSB = 26;
  localparam int CMN_Y_MSB = 25;
  localparam int CMN_Y_LSB = 21;
  localparam int CMN_Z_MSB = 20;
  localparam int CMN_Z_LSB = 16;
  localparam int CMN_X_MSB = 15;
  localparam int CMN_X_LSB = 11;
  localparam int CMN_IMM_MSB = 15;
  localparam int CMN_PAD_MSB = 10;
  localparam logic [10:0] CMN_PAD_ZERO = 11'h000;
  localparam logic [15:0] CMN_HALF_ZERO = 16'h0000;
  localparam logic [31:0] CMN_WORD_ZERO = 32'h0000_0000;
  localparam logic [4:0] CMN_REG_ZERO = 5'h00;

  // ==========================================================================
  // Timing
  localparam int CMN_DIV_CYCLES = 34;
  localparam int CMN_MUL_CYCLES = 3;
  localparam int CMN_LOGIC_CYCLES = 1;
  localparam int CMN_DIV_STEPS = 32;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    CMN_K_NONE = 3'b000,
    CMN_K_MODU = 3'b001,
    CMN_K_MUL = 3'b010,
    CMN_K_LOGIC = 3'b011,
    CMN_K_ILLEGAL = 3'b100
  } cmn_kind_t;

  typedef struct packed {
    logic valid;
    logic [4:0] dest;
    logic [31:0] data;
  } cmn_wb_t;

  typedef struct packed {
    logic [4:0] ry;
    logic [4:0] rz;
  } cmn_rd_t;

endpackage

// ==== design/cmn_divider.sv ====
`timescale 1ns/1ns
`default_nettype none
module cmn_divider
  import cmn_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [WIDTH-1:0] dividend,
  input wire logic [WIDTH-1:0] divisor,
  output logic busy,
  output logic done,
  output logic [WIDTH-1:0] remainder
);

  // ==========================================================================
  // Restoring unsigned division, one quotient bit per cycle.
  logic [WIDTH-1:0] quo_r;
  logic [WIDTH-1:0] den_r;
  logic [WIDTH:0] rem_r;
  logic [5:0] step_r;
  logic [WIDTH:0] trial;
  logic [WIDTH:0] shifted;

  assign shifted = {rem_r[WIDTH-1:0], quo_r[WIDTH-1]};
  assign trial = shifted - {1'b0, den_r};
  assign remainder = rem_r[WIDTH-1:0];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      done <= 1'b0;
      step_r <= 6'h00;
      quo_r <= '0;
      den_r <= '0;
      rem_r <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        step_r <= 6'h00;
        quo_r <= dividend;
        den_r <= divisor;
        rem_r <= '0;
      end else if (busy) begin
        quo_r <= {quo_r[WIDTH-2:0], ~trial[WIDTH]};
        rem_r <= trial[WIDTH] ? shifted : trial;
        step_r <= step_r + 6'h01;
        if (step_r == 6'(CMN_DIV_STEPS - 1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== design/cmn_multiplier.sv ====
`timescale 1ns/1ns
`default_nettype none
module cmn_multiplier
  import cmn_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [WIDTH-1:0] a,
  input wire logic [WIDTH-1:0] b,
  output logic [WIDTH-1:0] product
);

  // ==========================================================================
  // Two register stages; only the low word of the product is kept.
  logic [WIDTH-1:0] a_r;
  logic [WIDTH-1:0] b_r;
  logic [2*WIDTH-1:0] full;

  assign full = a_r * b_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      a_r <= '0;
      b_r <= '0;
      product <= '0;
    end else begin
      if (start) begin
        a_r <= a;
        b_r <= b;
      end
      product <= full[WIDTH-1:0];
    end
  end

endmodule
`default_nettype wire

// ==== design/cmn_exec.sv ====
`timescale 1ns/1ns
`default_nettype none
module cmn_exec
  import cmn_pkg::*;
#(
  parameter bit DIVIDER_OPTION = 1'b1,
  parameter bit MULTICYCLE_MULTIPLIER_OPTION = 1'b0,
  parameter bit PIPELINED_MULTIPLIER_OPTION = 1'b1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic issue_valid,
  input wire logic [31:0] issue_instr,
  output logic issue_ready,
  output cmn_rd_t rd_addr,
  input wire logic [31:0] rd_y_data,
  input wire logic [31:0] rd_z_data,
  output cmn_wb_t wb,
  output logic illegal
);

  // ==========================================================================
  // Option derivation.
  localparam bit HAS_DIV = DIVIDER_OPTION;
  localparam bit HAS_MUL = MULTICYCLE_MULTIPLIER_OPTION
                           | PIPELINED_MULTIPLIER_OPTION;

  // ==========================================================================
  // Decode.
  function automatic logic [31:0] sext16(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction

  function automatic logic [31:0] zext16(input logic [15:0] v);
    return {CMN_HALF_ZERO, v};
  endfunction

  logic [5:0] op;
  logic [4:0] fy;
  logic [4:0] fz;
  logic [4:0] fx;
  logic [15:0] imm;
  logic pad_ok;
  cmn_kind_t kind;
  logic [4:0] dest;
  logic [31:0] logic_res;
  logic [31:0] mul_b;
  logic [31:0] y_val;
  logic [31:0] z_val;

  assign op = issue_instr[CMN_OP_MSB:CMN_OP_LSB];
  assign fy = issue_instr[CMN_Y_MSB:CMN_Y_LSB];
  assign fz = issue_instr[CMN_Z_MSB:CMN_Z_LSB];
  assign fx = issue_instr[CMN_X_MSB:CMN_X_LSB];
  assign imm = issue_instr[CMN_IMM_MSB:0];
  assign pad_ok = issue_instr[CMN_PAD_MSB:0] == CMN_PAD_ZERO;

  // The register file port is combinational; register zero always reads zero.
  assign rd_addr.ry = fy;
  assign rd_addr.rz = fz;
  assign y_val = (fy == CMN_REG_ZERO) ? CMN_WORD_ZERO : rd_y_data;
  assign z_val = (fz == CMN_REG_ZERO) ? CMN_WORD_ZERO : rd_z_data;

  always_comb begin
    kind = CMN_K_ILLEGAL;
    dest = fx;
    logic_res = CMN_WORD_ZERO;
    mul_b = z_val;
    case (op)
      CMN_OP_MODU: begin
        kind = (HAS_DIV && pad_ok) ? CMN_K_MODU : CMN_K_ILLEGAL;
      end
      CMN_OP_MUL: begin
        kind = (HAS_MUL && pad_ok) ? CMN_K_MUL : CMN_K_ILLEGAL;
      end
      CMN_OP_MULI: begin
        kind = HAS_MUL ? CMN_K_MUL : CMN_K_ILLEGAL;
        dest = fz;
        mul_b = sext16(imm);
      end
      CMN_OP_NOR: begin
        kind = pad_ok ? CMN_K_LOGIC : CMN_K_ILLEGAL;
        logic_res = ~(y_val | z_val);
      end
      CMN_OP_NORI: begin
        kind = CMN_K_LOGIC;
        dest = fz;
        logic_res = ~(y_val | zext16(imm));
      end
      CMN_OP_OR: begin
        // Copy_register is an OR with register zero as the Z operand.
        kind = pad_ok ? CMN_K_LOGIC : CMN_K_ILLEGAL;
        logic_res = y_val | z_val;
      end
      CMN_OP_ORHI: begin
        // Move-high is an OR-high with register zero as the Y operand.
        kind = CMN_K_LOGIC;
        dest = fz;
        logic_res = y_val | {imm, CMN_HALF_ZERO};
      end
      default: begin
        kind = CMN_K_ILLEGAL;
      end
    endcase
  end

  // ==========================================================================
  // Issue control: the remainder holds issue for its whole issue interval.
  typedef enum logic [1:0] {
    CMN_DS_IDLE = 2'b00,
    CMN_DS_RUN = 2'b01
  } cmn_div_state_t;

  function automatic logic takes_kind(input logic t, input cmn_kind_t k,
                                      input cmn_kind_t want);
    return t && (k == want);
  endfunction

  logic take;
  logic take_div;
  logic take_mul;
  logic take_logic;
  logic take_bad;
  logic div_done;
  logic [31:0] div_rem;
  logic [31:0] mul_prod;
  cmn_div_state_t div_state_r;
  cmn_div_state_t div_state_nxt;
  logic [4:0] div_dest_r;
  logic [5:0] div_cnt_r;
  logic [5:0] div_cnt_nxt;
  logic [1:0] mul_v_r;
  logic [4:0] mul_d0_r;
  logic [4:0] mul_d1_r;

  assign take = issue_valid && issue_ready;
  assign take_div = takes_kind(take, kind, CMN_K_MODU);
  assign take_mul = takes_kind(take, kind, CMN_K_MUL);
  assign take_logic = takes_kind(take, kind, CMN_K_LOGIC);
  assign take_bad = takes_kind(take, kind, CMN_K_ILLEGAL);
  assign div_cnt_nxt = div_cnt_r - 6'h01;

  cmn_divider #(.WIDTH(32)) u_div (
    .clk(clk),
    .resetn(resetn),
    .start(take_div),
    .dividend(y_val),
    .divisor(z_val),
    .busy(),
    .done(div_done),
    .remainder(div_rem)
  );

  cmn_multiplier #(.WIDTH(32)) u_mul (
    .clk(clk),
    .resetn(resetn),
    .start(take_mul),
    .a(y_val),
    .b(mul_b),
    .product(mul_prod)
  );

  // The sequencer leaves its run state on the edge that reopens issue, so the
  // next instruction can be taken exactly 34 cycles after the remainder.
  always_comb begin
    div_state_nxt = div_state_r;
    case (div_state_r)
      CMN_DS_IDLE: begin
        if (take_div) begin
          div_state_nxt = CMN_DS_RUN;
        end
      end
      CMN_DS_RUN: begin
        if (div_cnt_nxt == 6'h00) begin
          div_state_nxt = CMN_DS_IDLE;
        end
      end
      default: begin
        div_state_nxt = CMN_DS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_state_r <= CMN_DS_IDLE;
      issue_ready <= 1'b1;
    end else begin
      div_state_r <= div_state_nxt;
      issue_ready <= div_state_nxt == CMN_DS_IDLE;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt_r <= 6'h00;
    end else if (take_div) begin
      div_cnt_r <= 6'(CMN_DIV_CYCLES - 1);
    end else if (div_state_r == CMN_DS_RUN) begin
      div_cnt_r <= div_cnt_nxt;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_dest_r <= CMN_REG_ZERO;
    end else if (take_div) begin
      div_dest_r <= dest;
    end
  end

  // Multiply tags follow the two product stages.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mul_v_r <= 2'b00;
      mul_d0_r <= CMN_REG_ZERO;
      mul_d1_r <= CMN_REG_ZERO;
    end else begin
      mul_v_r <= {mul_v_r[0], take_mul};
      mul_d0_r <= dest;
      mul_d1_r <= mul_d0_r;
    end
  end

  // ==========================================================================
  // Write-back. A logic result lands in the cycle after issue, a multiply
  // result two cycles later and the remainder in the 34th cycle. Results that
  // meet in one slot go remainder first, then multiply; the loser is lost, so
  // instruction order must keep such slots apart.
  function automatic cmn_wb_t make_wb(input logic v, input logic [4:0] d,
                                      input logic [31:0] x);
    cmn_wb_t w;
    w = '0;
    if (v) begin
      w.valid = 1'b1;
      w.dest = d;
      w.data = x;
    end
    return w;
  endfunction

  cmn_wb_t div_wb;
  cmn_wb_t mul_wb;
  cmn_wb_t logic_wb;

  assign div_wb = make_wb(div_done, div_dest_r, div_rem);
  assign mul_wb = make_wb(mul_v_r[1], mul_d1_r, mul_prod);
  assign logic_wb = make_wb(take_logic, dest, logic_res);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wb <= '0;
    end else if (div_wb.valid) begin
      wb <= div_wb;
    end else if (mul_wb.valid) begin
      wb <= mul_wb;
    end else begin
      wb <= logic_wb;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      illegal <= 1'b0;
    end else begin
      illegal <= take_bad;
    end
  end

endmodule
`default_nettype wire

// ==== bench/cmn_exec_props.sv ====
`timescale 1ns/1ns
`default_nettype none
module cmn_exec_props
  import cmn_pkg::*;
#(
  parameter bit DIVIDER_OPTION = 1'b1,
  parameter bit MULTICYCLE_MULTIPLIER_OPTION = 1'b0,
  parameter bit PIPELINED_MULTIPLIER_OPTION = 1'b1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic issue_valid,
  input wire logic [31:0] issue_instr,
  input wire logic issue_ready,
  input wire cmn_rd_t rd_addr,
  input wire logic [31:0] rd_y_data,
  input wire logic [31:0] rd_z_data,
  input wire cmn_wb_t wb,
  input wire logic illegal
);
  // ==========================================
  // Decode helpers.
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [5:0] op;
  logic [4:0] ry, rz, dx, di;
  logic [15:0] im;
  logic tk, pad0, nz, mon;
  logic [31:0] prod, prodi, rem;
  logic [5:0] wait_r;
  assign op = issue_instr[31:26];
  assign ry = issue_instr[25:21];
  assign rz = issue_instr[20:16];
  assign dx = issue_instr[15:11];
  assign di = issue_instr[20:16];
  assign im = issue_instr[15:0];
  assign tk = issue_valid && issue_ready;
  assign pad0 = issue_instr[10:0] == 11'h000;
  assign nz = ry != 5'h00 && rz != 5'h00;
  assign mon = MULTICYCLE_MULTIPLIER_OPTION || PIPELINED_MULTIPLIER_OPTION;
  assign prod = rd_y_data * rd_z_data;
  assign prodi = rd_y_data * {{16{im[15]}}, im};
  assign rem = (rd_z_data == 32'h0000_0000) ? rd_y_data : rd_y_data % rd_z_data;
  // Counts the cycles left until a remainder may be followed by another issue.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_r <= 6'h00;
    end else if (tk && op == CMN_OP_MODU && pad0 && DIVIDER_OPTION) begin
      wait_r <= 6'h21;
    end else if (wait_r != 6'h00) begin
      wait_r <= wait_r - 6'h01;
    end
  end
  // ==========================================
  // Assertions.
  AST_READY: assert property (issue_ready == (wait_r == 6'h00))
    else $error("issue_ready wrong around remainder");
  AST_MODU: assert property (
    tk && op == CMN_OP_MODU && pad0 && nz && DIVIDER_OPTION |-> ##34
    wb.valid && wb.data == $past(rem, 34) && wb.dest == $past(dx, 34))
    else $error("remainder result wrong");
  AST_MUL: assert property (tk && op == CMN_OP_MUL && pad0 && nz && mon |-> ##3
    wb.valid && wb.data == $past(prod, 3) && wb.dest == $past(dx, 3))
    else $error("multiply result wrong");
  AST_MULI: assert property (tk && op == CMN_OP_MULI && ry != 5'h00 && mon |-> ##3
    wb.valid && wb.data == $past(prodi, 3) && wb.dest == $past(di, 3))
    else $error("immediate multiply result wrong");
  AST_NOR: assert property (tk && op == CMN_OP_NOR && pad0 && nz |=> wb.valid &&
    wb.data == ~($past(rd_y_data) | $past(rd_z_data)) && wb.dest == $past(dx))
    else $error("nor result wrong");
  AST_NORI: assert property (tk && op == CMN_OP_NORI && ry != 5'h00 |=> wb.valid &&
    wb.data == ~($past(rd_y_data) | {16'h0000, $past(im)}))
    else $error("immediate nor result wrong");
  AST_MOVE: assert property (tk && op == CMN_OP_OR && pad0 && ry != 5'h00 && rz == 5'h00
    |=> wb.valid && wb.data == $past(rd_y_data))
    else $error("register copy wrong");
  AST_MOVE_HIGH: assert property (tk && op == CMN_OP_ORHI && ry == 5'h00 |=> wb.valid &&
    wb.data == {$past(im), 16'h0000})
    else $error("move high wrong");
  AST_PAD: assert property (tk && !pad0 && (op == CMN_OP_NOR || op == CMN_OP_MUL)
    |=> illegal && !wb.valid)
    else $error("bad padding accepted");
  AST_RD: assert property (rd_addr == {ry, rz})
    else $error("read addresses wrong");
  cover property (tk && op == CMN_OP_MODU);
  cover property (tk && op == CMN_OP_MUL);
  cover property (illegal);
endmodule
bind cmn_exec cmn_exec_props #(.DIVIDER_OPTION(DIVIDER_OPTION),
  .MULTICYCLE_MULTIPLIER_OPTION(MULTICYCLE_MULTIPLIER_OPTION),
  .PIPELINED_MULTIPLIER_OPTION(PIPELINED_MULTIPLIER_OPTION)) u_props (.clk(clk),
  .resetn(resetn), .issue_valid(issue_valid), .issue_instr(issue_instr),
  .issue_ready(issue_ready), .rd_addr(rd_addr), .rd_y_data(rd_y_data),
  .rd_z_data(rd_z_data), .wb(wb), .illegal(illegal));
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin num_errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, a); end end
module tb_top
  import cmn_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic issue_valid = 1'b0;
  logic [31:0] issue_instr = 32'h0000_0000;
  logic [31:0] rd_y_data = 32'h0000_0000;
  logic [31:0] rd_z_data = 32'h0000_0000;
  logic issue_ready, illegal;
  cmn_rd_t rd_addr;
  cmn_wb_t wb;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  always #20 clk = ~clk;
  cmn_exec dut (.clk(clk), .resetn(resetn), .issue_valid(issue_valid),
    .issue_instr(issue_instr), .issue_ready(issue_ready), .rd_addr(rd_addr),
    .rd_y_data(rd_y_data), .rd_z_data(rd_z_data), .wb(wb), .illegal(illegal));
  // ==========================================
  // Bus helpers.
  function automatic logic [31:0] rf(logic [5:0] o, logic [4:0] y, logic [4:0] z,
    logic [4:0] x);
    return {o, y, z, x, 11'h000};
  endfunction
  function automatic logic [31:0] imf(logic [5:0] o, logic [4:0] y, logic [4:0] x,
    logic [15:0] im);
    return {o, y, x, im};
  endfunction
  task automatic drive(logic [31:0] ins, logic [31:0] y, logic [31:0] z);
    @(negedge clk);
    issue_valid = 1'b1;
    issue_instr = ins;
    rd_y_data = y;
    rd_z_data = z;
  endtask
  task automatic idle();
    @(negedge clk);
    issue_valid = 1'b0;
  endtask
  task automatic expect_wb(logic ok, logic [4:0] d, logic [31:0] v);
    `CHK("wb_valid", ok, wb.valid)
    `CHK("illegal", !ok, illegal)
    if (ok) begin
      `CHK("wb_dest", d, wb.dest)
      `CHK("wb_data", v, wb.data)
    end
  endtask
  task automatic run1(logic [31:0] ins, logic [31:0] y, logic [31:0] z, int lat, logic ok,
    logic [4:0] d, logic [31:0] v);
    drive(ins, y, z);
    idle();
    repeat (lat - 1) @(negedge clk);
    expect_wb(ok, d, v);
    `CHK("rd_addr", {ins[25:21], ins[20:16]}, rd_addr)
  endtask
  // ==========================================
  // Scenarios.
  task automatic t_nor_pair();
    drive(rf(CMN_OP_NOR, 5'h01, 5'h02, 5'h03), 32'h1234_00F0, 32'h0000_0F0F);
    drive(imf(CMN_OP_NORI, 5'h04, 5'h05, 16'h8001), 32'h0F00_0000, 32'hFFFF_FFFF);
    expect_wb(1'b1, 5'h03, ~(32'h1234_00F0 | 32'h0000_0F0F));
    idle();
    expect_wb(1'b1, 5'h05, ~(32'h0F00_0000 | 32'h0000_8001));
  endtask
  task automatic t_move();
    run1(rf(CMN_OP_OR, 5'h06, 5'h00, 5'h07), 32'hA5C3_0001, 32'hDEAD_BEEF, 1, 1'b1, 5'h07,
      32'hA5C3_0001);
    run1(imf(CMN_OP_ORHI, 5'h00, 5'h08, 16'h5A5A), 32'hFFFF_FFFF, 32'h0000_0000, 1, 1'b1,
      5'h08, 32'h5A5A_0000);
  endtask
  task automatic t_mul();
    drive(rf(CMN_OP_MUL, 5'h01, 5'h02, 5'h09), 32'h1234_5678, 32'h9ABC_DEF0);
    drive(imf(CMN_OP_MULI, 5'h03, 5'h0A, 16'hFFFD), 32'h0000_0005, 32'h0000_0000);
    idle();
    @(negedge clk);
    expect_wb(1'b1, 5'h09, 32'h1234_5678 * 32'h9ABC_DEF0);
    @(negedge clk);
    expect_wb(1'b1, 5'h0A, 32'hFFFF_FFF1);
  endtask
  task automatic t_modu();
    drive(rf(CMN_OP_MODU, 5'h0B, 5'h0C, 5'h0D), 32'hFFFF_FFF0, 32'h0000_0007);
    idle();
    drive(rf(CMN_OP_NOR, 5'h01, 5'h02, 5'h03), 32'h0, 32'h0);
    @(negedge clk);
    `CHK("wb_refused", 1'b0, wb.valid)
    repeat (30) @(negedge clk);
    `CHK("ready_busy", 1'b0, issue_ready)
    idle();
    expect_wb(1'b1, 5'h0D, 32'hFFFF_FFF0 % 32'h0000_0007);
    `CHK("ready_free", 1'b1, issue_ready)
    @(negedge clk);
    `CHK("wb_pulse", 1'b0, wb.valid)
  endtask
  task automatic t_illegal();
    run1(rf(CMN_OP_NOR, 5'h01, 5'h02, 5'h03) | 32'h1, 32'h1, 32'h2, 1, 1'b0, 5'h0,
      32'h0);
    run1({6'h3F, 26'h0}, 32'h1, 32'h2, 1, 1'b0, 5'h0, 32'h0);
  endtask
  // ==========================================
  // Run control.
  task automatic close_out();
    if (num_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    t_nor_pair();
    t_move();
    t_mul();
    t_modu();
    t_illegal();
    close_out();
  end
endmodule
`default_nettype wire
